// ---- common/dbu_pkg.sv ----
package dbu_pkg;
  localparam logic [11:0] DBU_CTRL_OFS = 12'h000;
  localparam logic [11:0] DBU_MODE_OFS = 12'h004;
  localparam logic [11:0] DBU_IEN_OFS = 12'h008;
  localparam logic [11:0] DBU_STAT_OFS = 12'h014;
  localparam logic [11:0] DBU_RHOLD_OFS = 12'h018;
  localparam logic [11:0] DBU_THOLD_OFS = 12'h01C;
  localparam logic [11:0] DBU_BAUD_OFS = 12'h020;
  localparam logic [11:0] DBU_CID_OFS = 12'h040;
  localparam logic [11:0] DBU_EXID_OFS = 12'h044;
  // Control command bits
  localparam int DBU_RX_RESET_CMD_BIT = 2;
  localparam int DBU_RSTTX_BIT = 3;
  localparam int DBU_RX_ENABLE_CMD_BIT = 4;
  localparam int DBU_RX_DISABLE_CMD_BIT = 5;
  localparam int DBU_TXEN_BIT = 6;
  localparam int DBU_TXDIS_BIT = 7;
  localparam int DBU_STATUS_RESET_CMD_BIT = 8;
  // Status bits
  localparam int DBU_RDY_BIT = 0;
  localparam int DBU_TXRDY_BIT = 1;
  localparam int DBU_OVR_BIT = 5;
  localparam int DBU_FRM_BIT = 6;
  localparam int DBU_PAR_BIT = 7;
  localparam int DBU_TXEMP_BIT = 9;
  localparam int DBU_DCCR_BIT = 30;
  localparam int DBU_DCCW_BIT = 31;
  // Mode fields: parity select at 11:9
  localparam int DBU_PAR_LSB = 9;
  localparam logic [2:0] DBU_PAR_NONE = 3'h4;
  localparam logic [2:0] DBU_MODE_RST = 3'h0;
  localparam int DBU_DIV_W = 16;
  localparam logic [15:0] DBU_DIV_RST = 16'h0000;
  localparam logic [3:0] DBU_OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] DBU_START_MIN = 4'h7;
  localparam logic [4:0] DBU_FIRST_SAMPLE = 5'h18;
  localparam logic [4:0] DBU_NEXT_SAMPLE = 5'h10;
  typedef enum logic [1:0] {DBU_RX_OFF, DBU_RX_HUNT, DBU_RX_SHIFT} dbu_rx_type;
endpackage

// ---- src/dbu_uart.sv ----
`timescale 1ns/1ps
module dbu_uart #(
  parameter logic [31:0] CHIP_ID = 32'h0000_0001,  // Arbitrary value
  parameter logic [31:0] EXT_ID = 32'h0000_0000  // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  input wire logic dcc_read_full,
  input wire logic dcc_write_full,
  output logic irq,
  output logic rx_xfer_req,
  output logic tx_xfer_req
);
  import dbu_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire wr_ctrl = wr && paddr == DBU_CTRL_OFS;
  wire wr_mode = wr && paddr == DBU_MODE_OFS;
  wire wr_ien = wr && paddr == DBU_IEN_OFS;
  wire wr_thold = wr && paddr == DBU_THOLD_OFS;
  wire wr_baud = wr && paddr == DBU_BAUD_OFS;
  wire rd_rhold = rd && paddr == DBU_RHOLD_OFS;
  wire mapped = paddr == DBU_CTRL_OFS || paddr == DBU_MODE_OFS || paddr == DBU_IEN_OFS
    || paddr == DBU_STAT_OFS || paddr == DBU_RHOLD_OFS || paddr == DBU_THOLD_OFS
    || paddr == DBU_BAUD_OFS || paddr == DBU_CID_OFS || paddr == DBU_EXID_OFS;
  wire cmd_rx_reset_cmd = wr_ctrl && pwdata[DBU_RX_RESET_CMD_BIT];
  wire cmd_rx_enable_cmd = wr_ctrl && pwdata[DBU_RX_ENABLE_CMD_BIT];
  wire cmd_rx_disable_cmd = wr_ctrl && pwdata[DBU_RX_DISABLE_CMD_BIT];
  wire cmd_rsttx = wr_ctrl && pwdata[DBU_RSTTX_BIT];
  wire cmd_txen = wr_ctrl && pwdata[DBU_TXEN_BIT];
  wire cmd_txdis = wr_ctrl && pwdata[DBU_TXDIS_BIT];
  wire cmd_status_reset_cmd = wr_ctrl && pwdata[DBU_STATUS_RESET_CMD_BIT];

  logic [DBU_DIV_W-1:0] clock_divisor;
  logic [2:0] par_mode;
  logic [31:0] ien;

  // ----------------------------------------------------------------
  // Baud generator, shared by both directions
  // ----------------------------------------------------------------
  logic [DBU_DIV_W-1:0] div_cnt;
  logic tick;
  wire div_on = clock_divisor != DBU_DIV_RST;
  wire div_wrap = div_cnt >= clock_divisor - 16'h0001;
  wire [DBU_DIV_W-1:0] next_div_cnt = (!div_on || div_wrap) ? 16'h0000 : div_cnt + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divisor <= DBU_DIV_RST;
      par_mode <= DBU_MODE_RST;
      ien <= 32'h0000_0000;
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      if (wr_baud) begin
        clock_divisor <= pwdata[DBU_DIV_W-1:0];
      end
      if (wr_mode) begin
        par_mode <= pwdata[DBU_PAR_LSB+:3];
      end
      if (wr_ien) begin
        ien <= pwdata;
      end
      div_cnt <= next_div_cnt;
      tick <= div_on && div_wrap;
    end
  end

  function automatic logic par_of(input logic [7:0] d, input logic [2:0] m);
    unique case (m)
      3'h0: par_of = ^d;
      3'h1: par_of = ~^d;
      3'h2: par_of = 1'b0;
      3'h3: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction
  wire par_en = par_mode[2] == 1'b0;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  dbu_rx_type rx_state;
  logic [3:0] low_cnt;
  logic [4:0] smp_cnt;
  logic [3:0] bit_idx;
  logic [8:0] shreg;
  logic stop_pending;
  logic [7:0] rx_holding_reg;
  logic rx_char_ready;
  logic rx_overrun_flag;
  logic frame_err;
  logic par_err;
  wire [3:0] last_idx = par_en ? 4'hA : 4'h9;
  wire smp_now = tick && smp_cnt == 5'h01;
  // A reset command in the stop-sample cycle must still drop the character
  wire char_done = rx_state == DBU_RX_SHIFT && smp_now && bit_idx == last_idx && !cmd_rx_reset_cmd;
  wire start_ok = tick && !serial_rx_line && low_cnt >= DBU_START_MIN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= DBU_RX_OFF;
      low_cnt <= 4'h0;
      smp_cnt <= 5'h00;
      bit_idx <= 4'h0;
      shreg <= 9'h000;
      stop_pending <= 1'b0;
    end else if (cmd_rx_reset_cmd) begin
      rx_state <= DBU_RX_OFF;
      stop_pending <= 1'b0;
      low_cnt <= 4'h0;
    end else begin
      unique case (rx_state)
        DBU_RX_OFF: begin
          if (cmd_rx_enable_cmd && !cmd_rx_disable_cmd) begin
            rx_state <= DBU_RX_HUNT;
          end
          low_cnt <= 4'h0;
        end
        DBU_RX_HUNT: begin
          if (cmd_rx_disable_cmd) begin
            rx_state <= DBU_RX_OFF;
          end else if (start_ok) begin
            rx_state <= DBU_RX_SHIFT;
            // Low run already spans 8 samples; 16 more reach first data centre
            smp_cnt <= DBU_NEXT_SAMPLE;
            bit_idx <= 4'h1;
          end else if (tick) begin
            low_cnt <= serial_rx_line ? 4'h0 : low_cnt + 4'h1;
          end
        end
        DBU_RX_SHIFT: begin
          if (cmd_rx_disable_cmd) begin
            stop_pending <= 1'b1;
          end
          if (smp_now) begin
            smp_cnt <= DBU_NEXT_SAMPLE;
            bit_idx <= bit_idx + 4'h1;
            shreg <= {serial_rx_line, shreg[8:1]};
          end else if (tick) begin
            smp_cnt <= smp_cnt - 5'h01;
          end
          if (char_done) begin
            rx_state <= (stop_pending || cmd_rx_disable_cmd) ? DBU_RX_OFF : DBU_RX_HUNT;
            stop_pending <= 1'b0;
            low_cnt <= 4'h0;
          end
        end
        default: rx_state <= DBU_RX_OFF;
      endcase
    end
  end

  // Data byte and parity sit in shreg when stop is sampled
  wire [7:0] fin_byte = par_en ? shreg[7:0] : shreg[8:1];
  wire par_bad = par_en && shreg[8] != par_of(fin_byte, par_mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding_reg <= 8'h00;
      rx_char_ready <= 1'b0;
      rx_overrun_flag <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
    end else begin
      if (char_done) begin
        rx_holding_reg <= fin_byte;
      end
      rx_char_ready <= char_done || (rx_char_ready && !rd_rhold);
      rx_overrun_flag <= (char_done && rx_char_ready)
        || (rx_overrun_flag && !cmd_status_reset_cmd);
      frame_err <= (char_done && !serial_rx_line) || (frame_err && !cmd_status_reset_cmd);
      par_err <= (char_done && par_bad) || (par_err && !cmd_status_reset_cmd);
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic tx_on;
  logic tx_stop_pending;
  logic [7:0] thold;
  logic thold_full;
  logic tx_busy;
  logic [10:0] tx_sh;
  logic [3:0] tx_bits;
  logic [3:0] tx_sub;
  wire tx_load = tx_on && !tx_busy && thold_full;
  wire tx_end = tx_busy && tick && tx_sub == DBU_OVERSAMPLE_LAST && tx_bits == 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_on <= 1'b0;
      tx_stop_pending <= 1'b0;
      thold <= 8'h00;
      thold_full <= 1'b0;
      tx_busy <= 1'b0;
      tx_sh <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_sub <= 4'h0;
      serial_tx_line <= 1'b1;
    end else if (cmd_rsttx) begin
      tx_on <= 1'b0;
      tx_stop_pending <= 1'b0;
      thold_full <= 1'b0;
      tx_busy <= 1'b0;
      serial_tx_line <= 1'b1;
    end else begin
      if (cmd_txdis) begin
        tx_stop_pending <= 1'b1;
      end else if (cmd_txen) begin
        tx_on <= 1'b1;
      end
      if (tx_stop_pending && !tx_busy && !thold_full) begin
        tx_on <= 1'b0;
        tx_stop_pending <= 1'b0;
      end
      if (wr_thold && tx_on) begin
        thold <= pwdata[7:0];
        thold_full <= 1'b1;
      end else if (tx_load) begin
        thold_full <= 1'b0;
      end
      if (tx_load) begin
        tx_busy <= 1'b1;
        tx_sh <= par_en ? {1'b1, par_of(thold, par_mode), thold, 1'b0}
                        : {2'b11, thold, 1'b0};
        tx_bits <= par_en ? 4'hB : 4'hA;
        tx_sub <= 4'h0;
      end else if (tx_busy && tick) begin
        serial_tx_line <= tx_sh[0];
        tx_sub <= tx_sub + 4'h1;
        if (tx_sub == DBU_OVERSAMPLE_LAST) begin
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_bits <= tx_bits - 4'h1;
        end
        if (tx_end) begin
          tx_busy <= 1'b0;
        end
      end else if (!tx_busy) begin
        serial_tx_line <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, read data, interrupt and transfer requests
  // ----------------------------------------------------------------
  wire txrdy = tx_on && !thold_full;
  wire [31:0] status = {dcc_write_full, dcc_read_full, 20'h00000, !tx_busy && !thold_full && tx_on,
    1'b0, par_err, frame_err, rx_overrun_flag, 3'h0, txrdy, rx_char_ready};
  wire [31:0] rd_mux = paddr == DBU_STAT_OFS ? status
    : paddr == DBU_RHOLD_OFS ? {24'h000000, rx_holding_reg}
    : paddr == DBU_MODE_OFS ? {20'h00000, par_mode, 9'h000}
    : paddr == DBU_IEN_OFS ? ien
    : paddr == DBU_BAUD_OFS ? {16'h0000, clock_divisor}
    : paddr == DBU_CID_OFS ? CHIP_ID
    : paddr == DBU_EXID_OFS ? EXT_ID : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      irq <= 1'b0;
      rx_xfer_req <= 1'b0;
      tx_xfer_req <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= rd_mux;
      pslverr <= psel && !penable && !mapped;
      irq <= |(status & ien);
      rx_xfer_req <= rx_char_ready && !rd_rhold;
      tx_xfer_req <= txrdy && !wr_thold;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  rx_reset_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_rx_reset_cmd |=> rx_state == DBU_RX_OFF) else $error("rx reset ignored");
  hunt_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == DBU_RX_HUNT && cmd_rx_disable_cmd) |=> rx_state == DBU_RX_OFF)
    else $error("hunt not stopped");
  dis_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == DBU_RX_OFF && cmd_rx_enable_cmd && cmd_rx_disable_cmd && !cmd_rx_reset_cmd) |=> rx_state == DBU_RX_OFF)
    else $error("enable beat disable");
  enable_hunt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == DBU_RX_OFF && cmd_rx_enable_cmd && !cmd_rx_disable_cmd && !cmd_rx_reset_cmd) |=> rx_state == DBU_RX_HUNT)
    else $error("enable ignored");
  shift_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == DBU_RX_SHIFT && cmd_rx_disable_cmd && !cmd_rx_reset_cmd && !char_done) |=> rx_state == DBU_RX_SHIFT)
    else $error("character cut short");
  no_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    !div_on |=> !tick) else $error("baud runs at zero");
  tick_space_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && clock_divisor == 16'h0002 && !wr_baud) |=> !tick ##1 tick)
    else $error("baud period wrong");
  start_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_state == DBU_RX_SHIFT && $past(rx_state) == DBU_RX_HUNT) |-> ($past(tick)
    && $past(low_cnt) == DBU_START_MIN && !$past(serial_rx_line)))
    else $error("short start taken");
  ready_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    char_done |=> rx_char_ready && rx_holding_reg == $past(fin_byte))
    else $error("ready not set");
  overrun_a: assert property (@(posedge pclk) disable iff (!presetn)
    (char_done && rx_char_ready) |=> rx_overrun_flag) else $error("overrun missed");
endmodule // dbu_uart

// ---- testbench/dbu_host.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Serial host driving the receive line
// ----------------------------------------
module dbu_host #(
  parameter int BIT = 32
) (
  input wire logic pclk,
  output logic line
);
  // Line idles high between characters, as a pulled-up wire would
  initial line = 1'b1;

  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge pclk);
  endtask

  task automatic send(input logic [7:0] d);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) begin
      hold(d[i], BIT);
    end
    hold(1'b1, BIT);
  endtask
endmodule  // dbu_host

// ---- testbench/test_debug_uart_baud_and_receiver_control.sv ----
`timescale 1ns/1ps
module test_debug_uart_baud_and_receiver_control;
  import dbu_pkg::*;
  localparam int BIT = 16 * 2;
  localparam logic [31:0] CID = 32'h0000_0A5C;  // Arbitrary value
  localparam logic [31:0] XID = 32'h0000_1234;  // Arbitrary value
  localparam logic [31:0] RM = 32'h1 << DBU_RDY_BIT;
  localparam logic [31:0] OM = 32'h1 << DBU_OVR_BIT;
  typedef struct {
    logic [11:0] a;
    logic [31:0] m;
    logic [31:0] e;
    logic r;
    logic [1:0] dcc;
  } dbu_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic rx_line, tx_line, dcc_rd, dcc_wr, irq, rx_req, tx_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int miscompares = 0;
  int checks = 0;
  dbu_row_type rows [6] = '{
    '{DBU_BAUD_OFS, 32'h0000_FFFF, 32'h0, 1'b0, 2'b00},
    '{DBU_CID_OFS, 32'hFFFF_FFFF, CID, 1'b0, 2'b00},
    '{DBU_EXID_OFS, 32'hFFFF_FFFF, XID, 1'b0, 2'b00},
    '{DBU_STAT_OFS, RM | OM, 32'h0, 1'b0, 2'b00},
    '{DBU_STAT_OFS, 32'hC000_0000, 32'hC000_0000, 1'b0, 2'b11},
    '{12'h100, 32'hFFFF_FFFF, 32'h0, 1'b1, 2'b00}};

  dbu_uart #(.CHIP_ID(CID), .EXT_ID(XID)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_rx_line(rx_line),
    .serial_tx_line(tx_line), .dcc_read_full(dcc_rd), .dcc_write_full(dcc_wr),
    .irq(irq), .rx_xfer_req(rx_req), .tx_xfer_req(tx_req));
  dbu_host #(.BIT(BIT)) u_host (.pclk(pclk), .line(rx_line));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // A slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle keeps the next setup out of this time step
    @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic stat(input logic r, input logic o);
    rdchk(DBU_STAT_OFS, RM | OM, (o ? OM : 32'h0) | (r ? RM : 32'h0));
  endtask

  task automatic ctrl(input int b);
    apb(1'b1, DBU_CTRL_OFS, 32'h1 << b);
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dcc_rd = 1'b0;
    dcc_wr = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, tx_line}, 32'h1);
    chk({30'h0, rx_req, tx_req}, 32'h0);
    foreach (rows[i]) begin
      {dcc_wr, dcc_rd} <= rows[i].dcc;
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd & rows[i].m, rows[i].e);
      chk({31'h0, err}, {31'h0, rows[i].r});
    end
    $display("register table done");
    apb(1'b1, DBU_BAUD_OFS, 32'h0000_FFFF);
    rdchk(DBU_BAUD_OFS, 32'hFFFF_FFFF, 32'h0000_FFFF);
    apb(1'b1, DBU_BAUD_OFS, 32'h0000_0002);
    apb(1'b1, DBU_MODE_OFS, 32'(DBU_PAR_NONE) << DBU_PAR_LSB);
    u_host.send(8'hA5);
    stat(1'b0, 1'b0);
    apb(1'b1, DBU_CTRL_OFS, (32'h1 << DBU_RX_ENABLE_CMD_BIT) | (32'h1 << DBU_RX_DISABLE_CMD_BIT));
    u_host.send(8'hA5);
    stat(1'b0, 1'b0);
    $display("receiver off done");
    ctrl(DBU_RX_ENABLE_CMD_BIT);
    u_host.send(8'hA5);
    stat(1'b1, 1'b0);
    chk({31'h0, rx_req}, 32'h1);
    rdchk(DBU_RHOLD_OFS, 32'h0000_00FF, 32'h0000_00A5);
    stat(1'b0, 1'b0);
    $display("receive done");
    u_host.hold(1'b0, 7 * 2);
    u_host.hold(1'b1, BIT * 2);
    stat(1'b0, 1'b0);
    u_host.send(8'h3C);
    rdchk(DBU_RHOLD_OFS, 32'h0000_00FF, 32'h0000_003C);
    $display("short start done");
    u_host.send(8'h11);
    u_host.send(8'h22);
    stat(1'b1, 1'b1);
    ctrl(DBU_STATUS_RESET_CMD_BIT);
    stat(1'b1, 1'b0);
    apb(1'b0, DBU_RHOLD_OFS, 32'h0);
    $display("overrun done");
    fork
      u_host.send(8'h5A);
      begin
        repeat (BIT * 3) @(posedge pclk);
        ctrl(DBU_RX_DISABLE_CMD_BIT);
      end
    join
    rdchk(DBU_RHOLD_OFS, 32'h0000_00FF, 32'h0000_005A);
    ctrl(DBU_RX_ENABLE_CMD_BIT);
    ctrl(DBU_RX_DISABLE_CMD_BIT);
    u_host.send(8'h77);
    stat(1'b0, 1'b0);
    $display("disable done");
    ctrl(DBU_RX_ENABLE_CMD_BIT);
    fork
      u_host.send(8'h99);
      begin
        repeat (BIT * 3) @(posedge pclk);
        ctrl(DBU_RX_RESET_CMD_BIT);
      end
    join
    stat(1'b0, 1'b0);
    ctrl(DBU_RX_ENABLE_CMD_BIT);
    u_host.send(8'h81);
    rdchk(DBU_RHOLD_OFS, 32'h0000_00FF, 32'h0000_0081);
    $display("receiver reset done");
    dcc_rd <= 1'b1;
    apb(1'b1, DBU_IEN_OFS, 32'h1 << DBU_DCCR_BIT);
    rdchk(DBU_STAT_OFS, 32'h1 << DBU_DCCR_BIT, 32'h1 << DBU_DCCR_BIT);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    dcc_rd <= 1'b0;
    dcc_wr <= 1'b1;
    rdchk(DBU_STAT_OFS, 32'h1 << DBU_DCCW_BIT, 32'h1 << DBU_DCCW_BIT);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("debug channel done");
    apb(1'b1, DBU_BAUD_OFS, 32'h0);
    ctrl(DBU_RX_ENABLE_CMD_BIT);
    u_host.send(8'hC3);
    stat(1'b0, 1'b0);
    $display("divisor zero done");
    dcc_rd <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, irq, rx_req, tx_req}, 32'h0);
    rdchk(DBU_BAUD_OFS, 32'h0000_FFFF, 32'h0);
    apb(1'b1, DBU_BAUD_OFS, 32'h0000_0002);
    apb(1'b1, DBU_MODE_OFS, 32'(DBU_PAR_NONE) << DBU_PAR_LSB);
    u_host.send(8'hE7);
    stat(1'b0, 1'b0);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule  // test_debug_uart_baud_and_receiver_control
